//--- hw/pcap_map.svh
// Register offsets, field positions, reset values and timing counts of the configuration access port
`ifndef PCAP_MAP_SVH
`define PCAP_MAP_SVH
`define PCAP_ADDR_PORT     16'h0cf8
`define PCAP_DATA_PORT     16'h0cfc
`define PCAP_ADDR_RESET    32'h0000_0000
`define PCAP_DATA_RESET    32'h0000_0000
`define PCAP_WMASK         32'h80ff_fffc
`define PCAP_EN_BIT        31
`define PCAP_BUS_HI        23
`define PCAP_BUS_LO        16
`define PCAP_DEV_HI        15
`define PCAP_DEV_LO        11
`define PCAP_FN_HI         10
`define PCAP_FN_LO         8
`define PCAP_REG_HI        7
`define PCAP_REG_LO        2
`define PCAP_BRIDGE_DEV    5'h00
`define PCAP_BRIDGE_FN     3'h0
`define PCAP_CMD_IORD      4'h2
`define PCAP_CMD_IOWR      4'h3
`define PCAP_CMD_CFGRD     4'ha
`define PCAP_CMD_CFGWR     4'hb
`define PCAP_DEVSEL_WAIT   8'h05
`endif

//--- hw/pcap_pkg.sv
// Types shared by the configuration access port
package pcap_pkg;
    typedef enum logic [2:0] {
        PCAP_IDLE = 3'b000,
        PCAP_ADDR = 3'b001,
        PCAP_DATA = 3'b010,
        PCAP_DONE = 3'b011,
        PCAP_LOCAL = 3'b100
    } pcap_state_e;
    typedef logic [31:0] pcap_word_t;
endpackage

//--- hw/pcap_cfg_ram.sv
// Configuration register space of the host bridge itself
`timescale 1ns/1ps
module pcap_cfg_ram #(
    parameter int DEPTH = 64
) (
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        we,
    input  wire logic [5:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  be,
    output logic      [31:0] rdata
);
    initial begin
        if (DEPTH != 64) $error("pcap_cfg_ram: depth must be 64");
    end
    logic [31:0] mem [DEPTH];
    // Byte-lane write, registered read
    always_ff @(posedge clk) begin
        if (ce) begin
            for (int i = 0; i < 4; i++) begin
                if (we && be[i]) mem[addr][8*i +: 8] <= wdata[8*i +: 8];
            end
            rdata <= mem[addr];
        end
    end
endmodule // pcap_cfg_ram

//--- hw/pcap_port.sv
// Configuration address/data port that turns processor I/O cycles into PCI cycles
`timescale 1ns/1ps
`include "pcap_map.svh"
module pcap_port #(
    parameter int WAIT_MAX = 8
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    input  wire logic        ioReq,
    input  wire logic        ioWrite,
    input  wire logic [15:0] ioAddr,
    input  wire logic [3:0]  ioByteEn,
    input  wire logic [31:0] ioWdata,
    output logic      [31:0] ioRdata,
    output logic             ioAck,
    output logic             busy,
    output logic      [31:0] adOut,
    output logic             adOe,
    input  wire logic [31:0] adIn,
    output logic      [3:0]  cbeOut,
    output logic             frameN,
    output logic             irdyN,
    input  wire logic        trdyN,
    input  wire logic        devselN,
    output logic      [31:0] cfgAddrOut
);
    initial begin
        if (WAIT_MAX < 2 || WAIT_MAX > 255) $error("pcap_port: WAIT_MAX out of range");
    end

    // ==========================================================
    // Pin synchronisers
    logic [1:0] trdySync_ff;
    logic [1:0] devselSync_ff;
    logic [31:0] adSync1_ff;
    logic [31:0] adSync2_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trdySync_ff   <= 2'h3;
            devselSync_ff <= 2'h3;
            adSync1_ff    <= 32'h0;
            adSync2_ff    <= 32'h0;
        end else if (clkEn) begin
            trdySync_ff   <= {trdySync_ff[0], trdyN};
            devselSync_ff <= {devselSync_ff[0], devselN};
            adSync1_ff    <= adIn;
            adSync2_ff    <= adSync1_ff;
        end
    end
    // AD and ready share the same two-flop lag, so read data and ready line up
    wire trdyS   = trdySync_ff[1];
    wire devselS = devselSync_ff[1];

    // ==========================================================
    // Address decode
    logic [31:0] cfgAddr_ff;
    logic [31:0] cfgData_ff;
    pcap_pkg::pcap_state_e state_ff, nxt_state;
    wire         idle      = (state_ff == pcap_pkg::PCAP_IDLE);
    wire         take      = ioReq && idle;
    wire         hitAddr   = (ioAddr == `PCAP_ADDR_PORT);
    wire         hitData   = (ioAddr == `PCAP_DATA_PORT);
    wire         fullWord  = (ioByteEn == 4'hf);
    wire         cfgEn     = cfgAddr_ff[`PCAP_EN_BIT];
    wire [7:0]   busNum    = cfgAddr_ff[`PCAP_BUS_HI:`PCAP_BUS_LO];
    wire [4:0]   devNum    = cfgAddr_ff[`PCAP_DEV_HI:`PCAP_DEV_LO];
    wire [2:0]   fnNum     = cfgAddr_ff[`PCAP_FN_HI:`PCAP_FN_LO];
    wire [5:0]   regIdx    = cfgAddr_ff[`PCAP_REG_HI:`PCAP_REG_LO];
    wire         busZero   = (busNum == 8'h00);
    wire         toBridge  = busZero && devNum == `PCAP_BRIDGE_DEV;
    wire         bridgeFn  = toBridge && fnNum == `PCAP_BRIDGE_FN;
    wire         addrLoad  = take && hitAddr && fullWord && ioWrite;
    wire         addrRead  = take && hitAddr && fullWord && !ioWrite;
    wire         cfgAccess = take && hitData && cfgEn;
    wire         localCfg  = cfgAccess && bridgeFn;
    wire         pciCfg    = cfgAccess && !toBridge;
    wire         deadCfg   = cfgAccess && toBridge && !bridgeFn;
    // Narrow address-port and disabled data-port accesses become I/O cycles
    wire         pciIo     = take && ((hitAddr && !fullWord) || (hitData && !cfgEn) ||
                                      (!hitAddr && !hitData));

    // ==========================================================
    // Address phase word for the two cycle types
    // Only devices 0 to 20 own a select line; a higher device number selects nobody
    wire [31:0] devSelOneHot = (devNum < 5'h15) ? (32'h0000_0800 << devNum) : 32'h0;
    wire [31:0] type0Word = devSelOneHot | {21'h0, fnNum, regIdx, 2'b00};
    wire [31:0] type1Word = {8'h00, busNum, devNum, fnNum, regIdx, 2'b01};
    wire [31:0] cfgAddrWord = busZero ? type0Word : type1Word;
    wire [3:0]  cfgCmd = ioWrite ? `PCAP_CMD_CFGWR : `PCAP_CMD_CFGRD;
    wire [3:0]  ioCmd  = ioWrite ? `PCAP_CMD_IOWR : `PCAP_CMD_IORD;

    // ==========================================================
    // Bridge-local configuration space
    logic [31:0] ramRdata;
    // Read data comes out of a register, so a local read answers two cycles after the take
    pcap_cfg_ram #(.DEPTH(64)) u_ram (
        .clk   (clk),
        .ce    (clkEn && localCfg),
        .we    (ioWrite),
        .addr  (regIdx),
        .wdata (ioWdata),
        .be    (ioByteEn),
        .rdata (ramRdata)
    );

    // ==========================================================
    // Cycle sequencer
    logic        write_ff;
    logic [7:0]  wait_ff;
    logic [31:0] rdata_ff;
    logic        ack_ff;
    logic [31:0] ad_ff;
    logic        adOe_ff;
    logic [3:0]  cbe_ff;
    logic        frame_ff;
    logic        irdy_ff;
    logic [3:0]  be_ff;
    logic [31:0] wdata_ff;
    // An absent target would stall the processor, so the wait count ends the cycle as a master abort
    wire         timeout = (wait_ff == 8'(WAIT_MAX));
    wire         gotTrdy = !trdyS;
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            pcap_pkg::PCAP_IDLE:  if (pciCfg || pciIo) nxt_state = pcap_pkg::PCAP_ADDR;
                                  else if (localCfg) nxt_state = pcap_pkg::PCAP_LOCAL;
            pcap_pkg::PCAP_ADDR:  nxt_state = pcap_pkg::PCAP_DATA;
            pcap_pkg::PCAP_DATA:  if (gotTrdy || timeout) nxt_state = pcap_pkg::PCAP_DONE;
            pcap_pkg::PCAP_DONE:  nxt_state = pcap_pkg::PCAP_IDLE;
            pcap_pkg::PCAP_LOCAL: nxt_state = pcap_pkg::PCAP_IDLE;
            default:              nxt_state = pcap_pkg::PCAP_IDLE;
        endcase
    end

    // Configuration address register; reserved bits masked on load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgAddr_ff <= `PCAP_ADDR_RESET;
        end else if (clkEn && addrLoad) begin
            cfgAddr_ff <= ioWdata & `PCAP_WMASK;
        end
    end

    // Data window holds the last configuration write word or the last word read over PCI or from local space
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgData_ff <= `PCAP_DATA_RESET;
        end else if (clkEn) begin
            if (cfgAccess && ioWrite) cfgData_ff <= ioWdata;
            else if (state_ff == pcap_pkg::PCAP_DATA && gotTrdy && !write_ff && adOe_ff == 1'b0)
                cfgData_ff <= adSync2_ff;
            else if (state_ff == pcap_pkg::PCAP_LOCAL && !write_ff) cfgData_ff <= ramRdata;
        end
    end

    // Bus phase outputs; a master abort returns all ones as PCI does
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= pcap_pkg::PCAP_IDLE;
            write_ff <= 1'b0;
            wait_ff  <= 8'h00;
            rdata_ff <= 32'h0;
            ack_ff   <= 1'b0;
            ad_ff    <= 32'h0;
            adOe_ff  <= 1'b0;
            cbe_ff   <= 4'hf;
            frame_ff <= 1'b1;
            irdy_ff  <= 1'b1;
            be_ff    <= 4'h0;
            wdata_ff <= 32'h0;
        end else if (clkEn) begin
            state_ff <= nxt_state;
            ack_ff   <= 1'b0;
            unique case (state_ff)
                pcap_pkg::PCAP_IDLE: begin
                    write_ff <= ioWrite;
                    be_ff    <= ioByteEn;
                    wdata_ff <= ioWdata;
                    wait_ff  <= 8'h00;
                    if (addrLoad) ack_ff <= 1'b1;
                    if (addrRead) begin
                        rdata_ff <= cfgAddr_ff;
                        ack_ff   <= 1'b1;
                    end
                    if (deadCfg) begin
                        rdata_ff <= 32'hffff_ffff;
                        ack_ff   <= 1'b1;
                    end
                    if (pciCfg || pciIo) begin
                        ad_ff    <= pciCfg ? cfgAddrWord : {16'h0, ioAddr};
                        cbe_ff   <= pciCfg ? cfgCmd : ioCmd;
                        adOe_ff  <= 1'b1;
                        frame_ff <= 1'b0;
                    end
                end
                pcap_pkg::PCAP_ADDR: begin
                    frame_ff <= 1'b1;
                    irdy_ff  <= 1'b0;
                    cbe_ff   <= ~be_ff;
                    ad_ff    <= wdata_ff;
                    adOe_ff  <= write_ff;
                end
                pcap_pkg::PCAP_DATA: begin
                    wait_ff <= wait_ff + 8'h01;
                    if (gotTrdy || timeout) begin
                        irdy_ff  <= 1'b1;
                        adOe_ff  <= 1'b0;
                        cbe_ff   <= 4'hf;
                        rdata_ff <= gotTrdy ? adSync2_ff : 32'hffff_ffff;
                    end
                end
                pcap_pkg::PCAP_DONE: begin
                    ack_ff <= 1'b1;
                end
                pcap_pkg::PCAP_LOCAL: begin
                    rdata_ff <= ramRdata;
                    ack_ff   <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Output drive
    assign ioRdata    = rdata_ff;
    assign ioAck      = ack_ff;
    assign busy       = !idle;
    assign adOut      = ad_ff;
    assign adOe       = adOe_ff;
    assign cbeOut     = cbe_ff;
    assign frameN     = frame_ff;
    assign irdyN      = irdy_ff;
    assign cfgAddrOut = cfgAddr_ff;

    // ==========================================================
    // Checks
    // Target decode is not waited for; a missing target ends by timeout as a master abort
    wire unusedDevsel = devselS;
    a_addr_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (cfgAddr_ff & ~`PCAP_WMASK) == 32'h0)
        else $error("reserved address bits set");
    a_addr_readback: assert property (@(posedge clk) disable iff (rst)
        clkEn && addrRead |=> ioAck && ioRdata == $past(cfgAddr_ff))
        else $error("address read returned wrong word");
    a_narrow_no_load: assert property (@(posedge clk) disable iff (rst)
        clkEn && take && hitAddr && !fullWord |=> $stable(cfgAddr_ff))
        else $error("narrow write changed address register");
    a_dword_load: assert property (@(posedge clk) disable iff (rst)
        clkEn && addrLoad |=> cfgAddr_ff == ($past(ioWdata) & `PCAP_WMASK))
        else $error("dword write not loaded");
    a_io_forward: assert property (@(posedge clk) disable iff (rst)
        clkEn && pciIo |=> !frameN && adOut == {16'h0, $past(ioAddr)})
        else $error("I/O cycle address wrong");
    a_type0_onehot: assert property (@(posedge clk) disable iff (rst)
        clkEn && pciCfg && busZero |=> $onehot(ad_ff[31:11]) && ad_ff[1:0] == 2'b00)
        else $error("type 0 select not one-hot");
    a_type1_fields: assert property (@(posedge clk) disable iff (rst)
        clkEn && pciCfg && !busZero |=> ad_ff[23:16] == $past(busNum) && ad_ff[15:11] == $past(devNum)
        && ad_ff[1:0] == 2'b01)
        else $error("type 1 fields wrong");
    a_disabled_is_io: assert property (@(posedge clk) disable iff (rst)
        clkEn && take && hitData && !cfgEn |=> !frameN && cbeOut[3:1] == 3'b001)
        else $error("disabled data access not I/O");
    a_blocked_no_cfg: assert property (@(posedge clk) disable iff (rst)
        clkEn && take && !cfgEn |=> cbeOut[3:1] != 3'b101)
        else $error("config cycle while disabled");
    a_bridge_no_pci: assert property (@(posedge clk) disable iff (rst)
        clkEn && cfgAccess && toBridge |=> frameN)
        else $error("bridge access reached PCI");
    a_cfg_cmd_enabled: assert property (@(posedge clk) disable iff (rst)
        clkEn && pciCfg |=> !frameN && cbeOut[3:1] == 3'b101)
        else $error("config command wrong");
    a_read_releases_ad: assert property (@(posedge clk) disable iff (rst)
        clkEn && state_ff == pcap_pkg::PCAP_ADDR && !write_ff |=> !adOe)
        else $error("read data phase drives AD");
    a_abort_ones: assert property (@(posedge clk) disable iff (rst)
        clkEn && deadCfg |=> ioAck && ioRdata == 32'hffff_ffff)
        else $error("other function not refused");
    a_local_ack: assert property (@(posedge clk) disable iff (rst)
        clkEn && localCfg ##1 clkEn |=> ioAck)
        else $error("local access not acknowledged");
    c_type0: cover property (@(posedge clk) disable iff (rst) pciCfg && busZero);
    c_type1: cover property (@(posedge clk) disable iff (rst) pciCfg && !busZero);
    c_local: cover property (@(posedge clk) disable iff (rst) localCfg);
    c_io:    cover property (@(posedge clk) disable iff (rst) pciIo);
    c_dead:  cover property (@(posedge clk) disable iff (rst) deadCfg);
endmodule // pcap_port

//--- test/pcap_pci_agent.sv
// PCI target model that answers the bridge's configuration and I/O cycles
`timescale 1ns/1ps
module pcap_pci_agent (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        frameN,
    input  wire logic        irdyN,
    input  wire logic [31:0] adOut,
    input  wire logic [3:0]  cbeOut,
    input  wire logic        adOe,
    input  wire logic [3:0]  delay,
    output logic      [31:0] adIn,
    output logic             trdyN,
    output logic             devselN,
    output logic      [31:0] capAddr,
    output logic      [3:0]  capCmd,
    output logic      [3:0]  capBe,
    output logic      [31:0] capData,
    output int               frames
);
    logic [31:0] store;
    int          waitCnt;
    // ==========================================================
    // Target sequencer
    // Released AD lines toggle so a late sample never sees stale data
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            trdyN   <= 1'b1;
            devselN <= 1'b1;
            frames  <= 0;
            waitCnt <= 0;
            store   <= 32'h0;
            adIn    <= 32'h5a5a_a5a5;
        end else begin
            if (trdyN || capCmd[0]) adIn <= ~adIn;
            if (!frameN) begin
                capAddr <= adOut;
                capCmd  <= cbeOut;
                frames  <= frames + 1;
                waitCnt <= 0;
                devselN <= 1'b0;
            end else if (!irdyN && trdyN) begin
                waitCnt <= waitCnt + 1;
                if (waitCnt >= int'(delay)) begin
                    trdyN <= 1'b0;
                    capBe <= cbeOut;
                    if (capCmd[0]) begin
                        store   <= adOut;
                        capData <= adOut;
                    end else adIn <= store;
                end
            end else if (irdyN) begin
                trdyN   <= 1'b1;
                devselN <= 1'b1;
            end
        end
    end
endmodule // pcap_pci_agent

//--- test/tb_pci_config_access_port.sv
// Self-checking bench of the configuration access port
`timescale 1ns/1ps
`include "pcap_map.svh"
module tb_pci_config_access_port;
    logic        clk = 1'b0, rst = 1'b1, ioReq = 1'b0, ioWrite = 1'b0, clkEn = 1'b1;
    logic [15:0] ioAddr = 16'h0;
    logic [3:0]  ioByteEn = 4'hf, delay = 4'h0, cbeOut, capCmd, capBe;
    logic [31:0] ioWdata = 32'h0, ioRdata, adOut, adIn, cfgAddrOut, capAddr, capData, rd;
    logic        ioAck, busy, adOe, frameN, irdyN, trdyN, devselN;
    int          frames, f0, err_count = 0, tests_run = 0;
    // ==========================================================
    // Clock, 25 ns period
    always #12.5 clk = ~clk;
    pcap_port i_pcap_port (.clk(clk), .rst(rst), .clkEn(clkEn), .ioReq(ioReq), .ioWrite(ioWrite),
        .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioWdata(ioWdata), .ioRdata(ioRdata), .ioAck(ioAck),
        .busy(busy), .adOut(adOut), .adOe(adOe), .adIn(adIn), .cbeOut(cbeOut), .frameN(frameN),
        .irdyN(irdyN), .trdyN(trdyN), .devselN(devselN), .cfgAddrOut(cfgAddrOut));
    pcap_pci_agent i_pcap_pci_agent (.clk(clk), .rst(rst), .frameN(frameN), .irdyN(irdyN),
        .adOut(adOut), .cbeOut(cbeOut), .adOe(adOe), .delay(delay), .adIn(adIn), .trdyN(trdyN),
        .devselN(devselN), .capAddr(capAddr), .capCmd(capCmd), .capBe(capBe), .capData(capData),
        .frames(frames));
    // ==========================================================
    // Shared tasks
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // Request held until the ack is seen; bounded so a hang ends the run
    task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
        int n;
        @(negedge clk);
        ioReq = 1'b1;
        ioWrite = wr;
        ioAddr = a;
        ioByteEn = be;
        ioWdata = d;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ioAck !== 1'b1 && n < 200);
        rd = ioRdata;
        ioReq = 1'b0;
        if (n >= 200) begin
            err_count++;
            $display("[FAIL] %0t no ack", $time);
            end_of_test();
        end
    endtask
    task automatic set_addr(input logic [31:0] v);
        io(1'b1, `PCAP_ADDR_PORT, 4'hf, v);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check(cfgAddrOut, 32'h0, "address after reset");
        io(1'b0, `PCAP_ADDR_PORT, 4'hf, 32'h0);
        check(rd, `PCAP_ADDR_RESET, "address read after reset");
        $display("reset test done");
    endtask
    task automatic t_addr_reg();
        f0 = frames;
        set_addr(32'hffff_ffff);
        io(1'b0, `PCAP_ADDR_PORT, 4'hf, 32'h0);
        check(rd, 32'h80ff_fffc, "reserved bits");
        check(cfgAddrOut, 32'h80ff_fffc, "address copy");
        check(frames, f0, "dword access stays local");
        $display("address register test done");
    endtask
    task automatic t_narrow();
        f0 = frames;
        io(1'b1, `PCAP_ADDR_PORT, 4'h3, 32'h1234_5678);
        check(cfgAddrOut, 32'h80ff_fffc, "narrow write changed register");
        check(frames, f0 + 1, "narrow write frame count");
        check(capCmd, `PCAP_CMD_IOWR, "narrow write command");
        check(capAddr[15:0], `PCAP_ADDR_PORT, "narrow write address");
        check(capBe, 4'hc, "narrow write byte enables");
        io(1'b1, 16'h0080, 4'hf, 32'h0000_00a5);
        check(capAddr[15:0], 16'h0080, "other port address");
        check(frames, f0 + 2, "other port frame count");
        $display("narrow access test done");
    endtask
    task automatic t_disabled();
        set_addr(32'h0012_abcc);
        io(1'b0, `PCAP_DATA_PORT, 4'hf, 32'h0);
        check(capCmd, `PCAP_CMD_IORD, "disabled data read command");
        check(capAddr[15:0], `PCAP_DATA_PORT, "disabled data read address");
        $display("disabled window test done");
    endtask
    task automatic t_type1();
        delay = 4'h3;
        set_addr(32'h8012_abcc);
        io(1'b1, `PCAP_DATA_PORT, 4'hf, 32'hcafe_f00d);
        check(capAddr, 32'h0012_abcd, "type 1 address phase");
        check(capCmd, `PCAP_CMD_CFGWR, "type 1 write command");
        check(capData, 32'hcafe_f00d, "type 1 write data");
        io(1'b0, `PCAP_DATA_PORT, 4'hf, 32'h0);
        check(capCmd, `PCAP_CMD_CFGRD, "type 1 read command");
        check(rd, 32'hcafe_f00d, "type 1 read data");
        check({frameN, irdyN, adOe, busy}, 4'hc, "bus released after cycle");
        delay = 4'h0;
        $display("type 1 test done");
    endtask
    task automatic t_type0();
        int devs [3] = '{1, 7, 20};
        foreach (devs[i]) begin
            set_addr(32'h8000_0234 | (32'(devs[i]) << 11));
            io(1'b1, `PCAP_DATA_PORT, 4'hf, 32'h0);
            check(capAddr, (32'h1 << (11 + devs[i])) | 32'h234, "type 0 select");
        end
        $display("type 0 test done");
    endtask
    task automatic t_local();
        f0 = frames;
        set_addr(32'h8000_0014);
        io(1'b1, `PCAP_DATA_PORT, 4'hf, 32'ha5a5_0f0f);
        set_addr(32'h8000_0018);
        io(1'b1, `PCAP_DATA_PORT, 4'hf, 32'h1111_2222);
        set_addr(32'h8000_0014);
        io(1'b0, `PCAP_DATA_PORT, 4'hf, 32'h0);
        check(rd, 32'ha5a5_0f0f, "bridge register readback");
        set_addr(32'h8000_0314);
        io(1'b0, `PCAP_DATA_PORT, 4'hf, 32'h0);
        check(rd, 32'hffff_ffff, "bridge other function");
        check(frames, f0, "bridge accesses left the chip");
        $display("bridge local test done");
    endtask
    // A request while the clock enable is low must leave every register alone
    task automatic t_freeze();
        @(negedge clk);
        clkEn = 1'b0;
        ioReq = 1'b1;
        ioWrite = 1'b1;
        ioAddr = `PCAP_ADDR_PORT;
        ioByteEn = 4'hf;
        ioWdata = 32'h8000_0010;
        repeat (3) @(negedge clk);
        check(ioAck, 1'b0, "ack while frozen");
        check(cfgAddrOut, `PCAP_ADDR_RESET, "address loaded while frozen");
        ioReq = 1'b0;
        clkEn = 1'b1;
        $display("clock enable test done");
    endtask
    // With a delay of 15 the target never raises ready before the wait count runs out, so the read ends as a master abort
    task automatic t_abort();
        delay = 4'hf;
        set_addr(32'h8012_abcc);
        io(1'b0, `PCAP_DATA_PORT, 4'hf, 32'h0);
        check(rd, 32'hffff_ffff, "unanswered read aborts");
        check(capCmd, `PCAP_CMD_CFGRD, "aborted read command");
        delay = 4'h0;
        $display("master abort test done");
    endtask
    task automatic t_midreset();
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        check(cfgAddrOut, `PCAP_ADDR_RESET, "address during reset");
        check({frameN, irdyN, adOe, ioAck}, 4'hc, "bus outputs during reset");
        repeat (2) @(negedge clk);
        rst = 1'b0;
        io(1'b0, `PCAP_ADDR_PORT, 4'hf, 32'h0);
        check(rd, `PCAP_ADDR_RESET, "address read after second reset");
        $display("mid-run reset test done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_freeze();
        t_addr_reg();
        t_narrow();
        t_disabled();
        t_type1();
        t_type0();
        t_abort();
        t_midreset();
        t_local();
        end_of_test();
    end
endmodule // tb_pci_config_access_port
